// >>> sstx_top.sv
// serial master transmit unit with axi4-lite register slave
// assumes a single mclk domain; all registers are at most 8 bits, in word lanes
//
// Chosen here: the AXI4-Lite register port and the address map.
module sstx_top (
   input  wire logic        mclk,
   input  wire logic        rst_b,
   input  wire logic        clk_en,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic             serial_clock_pin,
   output logic             serial_data_out,
   output logic             select_port_line,
   output logic             irq
);
   // ----------------------------------------
   // registers
   // ----------------------------------------
   logic [7:0] transmit_holding_register_r;
   logic [7:0] transmit_shift_register_r;
   logic [7:0] mode_r;
   logic       transmit_enable_r;
   logic       transmit_empty_flag_r;
   logic       transmit_end_flag_r;
   logic [1:0] mask_r;
   logic [7:0] module_clock_stop_control_r;
   logic       aw_hold_r;
   logic       w_hold_r;
   logic [7:0] aw_addr_r;
   logic [31:0] w_data_r;
   logic       w_strb0_r;
   sstx_pkg::sstx_state_t state_r;
   logic [3:0] div_cnt_r;
   logic [2:0] bit_cnt_r;
   logic       half_r;
   logic       run;
   logic       wr_go;
   logic       rd_go;
   logic       wr_data;
   logic       rd_status;
   logic       tick;
   logic       last_bit;

   function automatic logic known(input logic [7:0] a);
      if (a == sstx_pkg::ADDR_DATA || a == sstx_pkg::ADDR_MODE ||
          a == sstx_pkg::ADDR_CTRL || a == sstx_pkg::ADDR_STATUS ||
          a == sstx_pkg::ADDR_MASK || a == sstx_pkg::ADDR_STOP ||
          a == sstx_pkg::ADDR_PORT)
         return 1'b1;
      else
         return 1'b0;
   endfunction

   // ----------------------------------------
   // axi4-lite handshake
   // ----------------------------------------
   // address and data latched independently, either order accepted
   assign s_axi_awready = clk_en && !aw_hold_r && !s_axi_bvalid;
   assign s_axi_wready  = clk_en && !w_hold_r && !s_axi_bvalid;
   assign s_axi_arready = clk_en && !s_axi_rvalid;
   assign wr_go = clk_en && aw_hold_r && w_hold_r && !s_axi_bvalid;
   assign rd_go = s_axi_arvalid && s_axi_arready;
   assign wr_data = wr_go && w_strb0_r && aw_addr_r == sstx_pkg::ADDR_DATA;
   assign rd_status = rd_go && s_axi_araddr == sstx_pkg::ADDR_STATUS;

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         aw_hold_r <= 1'b0;
         w_hold_r <= 1'b0;
         aw_addr_r <= 8'h00;
         w_data_r <= 32'h0000_0000;
         w_strb0_r <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= sstx_pkg::RESP_OKAY;
      end else if (clk_en) begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_hold_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb0_r <= s_axi_wstrb[0];
         end
         if (wr_go) begin
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= known(aw_addr_r) ? sstx_pkg::RESP_OKAY : sstx_pkg::RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // read data; a status read clears the end flag below
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= sstx_pkg::RESP_OKAY;
      end else if (clk_en) begin
         if (rd_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= sstx_pkg::RESP_OKAY;
            s_axi_rdata <= 32'h0000_0000;
            if (s_axi_araddr == sstx_pkg::ADDR_DATA)
               s_axi_rdata[7:0] <= transmit_holding_register_r;
            else if (s_axi_araddr == sstx_pkg::ADDR_MODE)
               s_axi_rdata[7:0] <= mode_r;
            else if (s_axi_araddr == sstx_pkg::ADDR_CTRL)
               s_axi_rdata[sstx_pkg::CTRL_ENABLE_BIT] <= transmit_enable_r;
            else if (s_axi_araddr == sstx_pkg::ADDR_STATUS) begin
               s_axi_rdata[sstx_pkg::ST_END_BIT] <= transmit_end_flag_r;
               s_axi_rdata[sstx_pkg::ST_EMPTY_BIT] <= transmit_empty_flag_r;
            end else if (s_axi_araddr == sstx_pkg::ADDR_MASK)
               s_axi_rdata[sstx_pkg::ST_END_BIT:sstx_pkg::ST_EMPTY_BIT] <= mask_r;
            else if (s_axi_araddr == sstx_pkg::ADDR_STOP)
               s_axi_rdata[7:0] <= module_clock_stop_control_r;
            else if (s_axi_araddr == sstx_pkg::ADDR_PORT)
               s_axi_rdata[0] <= select_port_line;
            else
               s_axi_rresp <= sstx_pkg::RESP_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // software registers
   // ----------------------------------------
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         transmit_holding_register_r <= 8'h00;
         mode_r <= sstx_pkg::MODE_RST;
         transmit_enable_r <= 1'b0;
         mask_r <= 2'h0;
         module_clock_stop_control_r <= sstx_pkg::STOP_RST;
         select_port_line <= 1'b1;
      end else if (clk_en && wr_go && w_strb0_r) begin
         if (aw_addr_r == sstx_pkg::ADDR_DATA)
            transmit_holding_register_r <= w_data_r[7:0];
         else if (aw_addr_r == sstx_pkg::ADDR_MODE)
            mode_r <= w_data_r[7:0];
         else if (aw_addr_r == sstx_pkg::ADDR_CTRL)
            transmit_enable_r <= w_data_r[sstx_pkg::CTRL_ENABLE_BIT];
         else if (aw_addr_r == sstx_pkg::ADDR_MASK)
            mask_r <= w_data_r[sstx_pkg::ST_END_BIT:sstx_pkg::ST_EMPTY_BIT];
         else if (aw_addr_r == sstx_pkg::ADDR_STOP)
            module_clock_stop_control_r <= w_data_r[7:0];
         else if (aw_addr_r == sstx_pkg::ADDR_PORT)
            select_port_line <= w_data_r[0];
      end
   end

   // ----------------------------------------
   // serial engine
   // ----------------------------------------
   // stop bit gates the whole engine, as a clock stop would
   assign run = clk_en && !module_clock_stop_control_r[sstx_pkg::STOP_UNIT_BIT];
   assign tick = div_cnt_r == (4'hF >> (3'h4 - mode_r[2:0]));
   assign last_bit = half_r && bit_cnt_r == 3'(sstx_pkg::BYTE_BITS - 1);

   // half-period divider: sixteen mclk per bit at the default select
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b)
         div_cnt_r <= 4'h0;
      else if (run) begin
         if (state_r != sstx_pkg::SST_SHIFT || tick)
            div_cnt_r <= 4'h0;
         else
            div_cnt_r <= div_cnt_r + 4'h1;
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         state_r <= sstx_pkg::SST_IDLE;
         transmit_shift_register_r <= 8'h00;
         bit_cnt_r <= 3'h0;
         half_r <= 1'b0;
      end else if (run) begin
         case (state_r)
            sstx_pkg::SST_IDLE: begin
               // no start without enable; clock stays idle
               if (transmit_enable_r && !transmit_empty_flag_r && !wr_data)
                  state_r <= sstx_pkg::SST_LOAD;
            end
            sstx_pkg::SST_LOAD: begin
               transmit_shift_register_r <= transmit_holding_register_r;
               bit_cnt_r <= 3'h0;
               half_r <= 1'b0;
               state_r <= sstx_pkg::SST_SHIFT;
            end
            default: begin
               if (tick) begin
                  half_r <= !half_r;
                  if (half_r) begin
                     // msb first when order select is set, else lsb
                     if (mode_r[sstx_pkg::MODE_ORDER_BIT])
                        transmit_shift_register_r <= {transmit_shift_register_r[6:0], 1'b0};
                     else
                        transmit_shift_register_r <= {1'b0, transmit_shift_register_r[7:1]};
                     bit_cnt_r <= bit_cnt_r + 3'h1;
                     if (last_bit)
                        state_r <= sstx_pkg::SST_IDLE;
                  end
               end
            end
         endcase
      end
   end

   // clock and data pins; polarity 0 idles high, phase 0 data leads
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         serial_clock_pin <= 1'b1;
         serial_data_out <= 1'b1;
      end else if (clk_en) begin
         serial_clock_pin <= (state_r == sstx_pkg::SST_SHIFT && !half_r) ^
                             !mode_r[sstx_pkg::MODE_POL_BIT];
         serial_data_out <= mode_r[sstx_pkg::MODE_ORDER_BIT] ?
                            transmit_shift_register_r[7] : transmit_shift_register_r[0];
      end
   end

   // ----------------------------------------
   // status flags, set wins over read-clear
   // ----------------------------------------
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         transmit_empty_flag_r <= 1'b1;
         transmit_end_flag_r <= 1'b0;
      end else if (clk_en) begin
         if (wr_data)
            transmit_empty_flag_r <= 1'b0;
         else if (run && state_r == sstx_pkg::SST_LOAD)
            transmit_empty_flag_r <= 1'b1;
         if (run && tick && last_bit && transmit_empty_flag_r && !wr_data)
            transmit_end_flag_r <= 1'b1;
         else if (rd_status || (wr_data))
            transmit_end_flag_r <= 1'b0;
      end
   end

   assign irq = (transmit_end_flag_r && mask_r[1]) || (transmit_empty_flag_r && mask_r[0]);

   // ----------------------------------------
   // checks
   // ----------------------------------------
   a_data_write_clears: assert property (@(posedge mclk) disable iff (!rst_b)
      clk_en && wr_data |=> !transmit_empty_flag_r)
      else $error("empty flag not cleared by data write");
   a_load_sets_empty: assert property (@(posedge mclk) disable iff (!rst_b)
      run && state_r == sstx_pkg::SST_LOAD && !wr_data |=> transmit_empty_flag_r)
      else $error("empty flag not set after load");
   a_load_copies_byte: assert property (@(posedge mclk) disable iff (!rst_b)
      run && state_r == sstx_pkg::SST_LOAD |=>
      transmit_shift_register_r == $past(transmit_holding_register_r))
      else $error("shift register not loaded");
   a_end_needs_empty: assert property (@(posedge mclk) disable iff (!rst_b)
      $rose(transmit_end_flag_r) |-> $past(transmit_empty_flag_r))
      else $error("end flag with byte pending");
   a_idle_clock_high: assert property (@(posedge mclk) disable iff (!rst_b)
      clk_en && !transmit_enable_r && state_r == sstx_pkg::SST_IDLE &&
      !mode_r[sstx_pkg::MODE_POL_BIT] |=> serial_clock_pin)
      else $error("serial clock not idle");
   a_stop_freezes: assert property (@(posedge mclk) disable iff (!rst_b)
      module_clock_stop_control_r[sstx_pkg::STOP_UNIT_BIT] |=> $stable(state_r))
      else $error("engine ran while stopped");
   sequence s_msb_load;
      run && state_r == sstx_pkg::SST_LOAD && mode_r[sstx_pkg::MODE_ORDER_BIT] ##2 1'b1;
   endsequence
   a_msb_first: assert property (@(posedge mclk) disable iff (!rst_b)
      s_msb_load |-> serial_data_out == $past(transmit_holding_register_r[7], 2))
      else $error("first bit not msb");
   a_bit_period: assert property (@(posedge mclk) disable iff (!rst_b)
      run && state_r == sstx_pkg::SST_SHIFT && div_cnt_r == 4'h0 && mode_r[2:0] ==
      sstx_pkg::DIV_SEL_16 && !tick |-> ##1 (div_cnt_r == 4'h1))
      else $error("divider not counting");
endmodule

// >>> sstx_pkg.sv
// package of constants for the serial master transmit block
// assumes an axi4-lite master on mclk and one 8-bit serial eeprom link
// Summary of operation
// - writing holding register clears empty flag
// - holding byte moves to shift register first
// - empty flag set once byte moves to shift register
// - end flag set after last bit, nothing pending
// - stop bit 2 high halts the unit
// - divider select 011 gives clock divide sixteen
// - order select 1 shifts msb first
// - polarity 0 idles high, phase 0 early data
package sstx_pkg;
   // ----------------------------------------
   // register byte addresses
   // ----------------------------------------
   localparam logic [7:0] ADDR_DATA   = 8'h00;
   localparam logic [7:0] ADDR_MODE   = 8'h04;
   localparam logic [7:0] ADDR_CTRL   = 8'h08;
   localparam logic [7:0] ADDR_STATUS = 8'h0C;
   localparam logic [7:0] ADDR_MASK   = 8'h10;
   localparam logic [7:0] ADDR_STOP   = 8'h14;
   localparam logic [7:0] ADDR_PORT   = 8'h18;
   // ----------------------------------------
   // field positions and reset values
   // ----------------------------------------
   localparam int MODE_ORDER_BIT  = 7;
   localparam int MODE_POL_BIT    = 6;
   localparam int MODE_PHASE_BIT  = 5;
   localparam int CTRL_ENABLE_BIT = 7;
   localparam int ST_END_BIT      = 3;
   localparam int ST_EMPTY_BIT    = 2;
   localparam int STOP_UNIT_BIT   = 2;
   localparam logic [7:0] MODE_RST = 8'h83;
   localparam logic [7:0] STOP_RST = 8'hFB;
   localparam logic [2:0] DIV_SEL_16 = 3'h3;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam int BYTE_BITS = 8;
   typedef enum logic [1:0] {SST_IDLE, SST_LOAD, SST_SHIFT} sstx_state_t;
endpackage

// >>> sstx_eeprom_model.sv
// behavioural serial eeprom receiver standing on the transmit link
// assumes spi mode with clock idling high and data valid at rising clock
module sstx_eeprom_model (
   input wire logic serial_clock_pin,
   input wire logic serial_data_out,
   input wire logic select_port_line
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] shift_r;
   logic [7:0] got[$];
   int         nbits;
   realtime    last_t;
   realtime    period;
   initial begin
      shift_r = 8'h00;
      nbits = 0;
      last_t = 0;
      period = 0;
   end
   // a deselect drops any partial byte, so frames never bleed together
   always @(posedge select_port_line) begin
      nbits = 0;
   end
   // sample on the rising edge, data having changed on the falling one
   always @(posedge serial_clock_pin) begin
      if (select_port_line === 1'b0) begin
         period = $realtime - last_t;
         last_t = $realtime;
         shift_r = {shift_r[6:0], serial_data_out};
         nbits++;
         if (nbits == 8) begin
            got.push_back(shift_r);
            nbits = 0;
         end
      end
   end
endmodule

// >>> test_sync_serial_master_transmit.sv
// self-checking bench for the serial master transmit unit
// assumes sstx_pkg and the eeprom model are compiled first
module test_sync_serial_master_transmit;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk, rst_b, clk_en, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid, sclk, sdo, sel, irq;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, s;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, r, frz;
   int miscompares, comparisons, n;
   sstx_top u_sstx_top (.mclk(mclk), .rst_b(rst_b), .clk_en(clk_en),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .serial_clock_pin(sclk),
      .serial_data_out(sdo), .select_port_line(sel), .irq(irq));
   sstx_eeprom_model u_sstx_eeprom_model (.serial_clock_pin(sclk),
      .serial_data_out(sdo), .select_port_line(sel));
   // ----------------------------------------
   // clock, reset and watchdog
   // ----------------------------------------
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   // far beyond the few thousand cycles the tests need
   initial begin
      #400000;
      miscompares++;
      conclude();
   end
   // ----------------------------------------
   // bus tasks and comparison
   // ----------------------------------------
   // readies are looked at mid-cycle, the handshake lands on the next rise
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic ta, tw, ad, wd, tb;
      @(posedge mclk);
      awaddr <= a; awvalid <= 1'b1; wdata <= d; wvalid <= 1'b1; bready <= 1'b1;
      ad = 0; wd = 0; tb = 0;
      while (!(ad && wd)) begin
         @(negedge mclk);
         ta = !ad && awready === 1'b1;
         tw = !wd && wready === 1'b1;
         @(posedge mclk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         ad |= ta; wd |= tw;
      end
      while (!tb) begin
         @(negedge mclk);
         tb = bvalid === 1'b1;
         r = bresp;
         @(posedge mclk);
      end
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      logic ta, tr;
      @(posedge mclk);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      ta = 0; tr = 0;
      while (!ta) begin
         @(negedge mclk);
         ta = arready === 1'b1;
         @(posedge mclk);
      end
      arvalid <= 1'b0;
      while (!tr) begin
         @(negedge mclk);
         tr = rvalid === 1'b1;
         d = rdata; r = rresp;
         @(posedge mclk);
      end
      rready <= 1'b0;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // status polling, bounded; note that each read clears the end flag
   task automatic poll(input logic [31:0] m);
      n = 0;
      do begin
         rd(sstx_pkg::ADDR_STATUS, s);
         n++;
      end while ((s & m) == 0 && n < 500);
   endtask
   task automatic conclude();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // ----------------------------------------
   // test sequence
   // ----------------------------------------
   initial begin
      rst_b = 1'b0; clk_en = 1'b1; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0;
      arvalid = 1'b0; rready = 1'b0; awaddr = 8'h00; araddr = 8'h00;
      wdata = 32'h0000_0000; wstrb = 4'hF; miscompares = 0; comparisons = 0;
      repeat (6) @(posedge mclk);
      rst_b <= 1'b1;
      rd(sstx_pkg::ADDR_STATUS, s); chk(s, 32'h0000_0004);
      rd(sstx_pkg::ADDR_MODE, s); chk(s, 32'h0000_0083);
      chk(r, sstx_pkg::RESP_OKAY);
      // a write with lane zero off must leave the register alone
      wstrb <= 4'h0;
      wr(sstx_pkg::ADDR_MODE, 32'h0000_0000);
      wstrb <= 4'hF;
      rd(sstx_pkg::ADDR_MODE, s);
      chk(s, 32'h0000_0083);
      rd(sstx_pkg::ADDR_STOP, s); chk(s, 32'h0000_00FB);
      rd(8'hFC, s); chk({r, s[29:0]}, {sstx_pkg::RESP_SLVERR, 30'h0});
      wr(8'hFC, 32'h0000_0000);
      chk(r, sstx_pkg::RESP_SLVERR);
      chk(sclk, 1'b1);
      wr(sstx_pkg::ADDR_PORT, 32'h0000_0000); chk(sel, 1'b0);
      chk(r, sstx_pkg::RESP_OKAY);
      rd(sstx_pkg::ADDR_PORT, s);
      chk(s, 32'h0000_0000);
      // byte loaded while disabled must wait
      wr(sstx_pkg::ADDR_DATA, 32'h0000_00A5);
      rd(sstx_pkg::ADDR_STATUS, s); chk(s, 32'h0000_0000);
      repeat (300) @(posedge mclk);
      chk(u_sstx_eeprom_model.got.size(), 0); chk(sclk, 1'b1);
      wr(sstx_pkg::ADDR_CTRL, 32'h0000_0080);
      poll(32'h0000_0008); chk(s, 32'h0000_000C);
      chk(u_sstx_eeprom_model.got[0], 8'hA5);
      chk(u_sstx_eeprom_model.period == 320.0, 1'b1);
      rd(sstx_pkg::ADDR_STATUS, s); chk(s, 32'h0000_0004);
      // back to back: second byte queued as soon as the first is taken
      wr(sstx_pkg::ADDR_DATA, 32'h0000_003C);
      poll(32'h0000_0004); chk(s, 32'h0000_0004);
      wr(sstx_pkg::ADDR_DATA, 32'h0000_00C3);
      poll(32'h0000_0008); chk(s, 32'h0000_000C);
      chk({u_sstx_eeprom_model.got[1], u_sstx_eeprom_model.got[2]}, 16'h3CC3);
      // interrupt on end, then on empty, then masked off
      wr(sstx_pkg::ADDR_MASK, 32'h0000_0008);
      wr(sstx_pkg::ADDR_DATA, 32'h0000_005A);
      n = 0;
      while (irq !== 1'b1 && n < 1000) begin
         @(posedge mclk);
         n++;
      end
      chk(irq, 1'b1);
      rd(sstx_pkg::ADDR_STATUS, s); @(negedge mclk); chk(irq, 1'b0);
      wr(sstx_pkg::ADDR_MASK, 32'h0000_0004); @(negedge mclk); chk(irq, 1'b1);
      wr(sstx_pkg::ADDR_MASK, 32'h0000_0000); @(negedge mclk); chk(irq, 1'b0);
      // stopped unit holds its byte until restarted
      wr(sstx_pkg::ADDR_STOP, 32'h0000_00FF);
      wr(sstx_pkg::ADDR_DATA, 32'h0000_0081);
      repeat (300) @(posedge mclk);
      chk(u_sstx_eeprom_model.got.size(), 4); chk(sclk, 1'b1);
      wr(sstx_pkg::ADDR_STOP, 32'h0000_00FB);
      poll(32'h0000_0008); chk(u_sstx_eeprom_model.got[4], 8'h81);
      // lsb first, and a low clock enable in mid-byte freezes the pins
      wr(sstx_pkg::ADDR_MODE, 32'h0000_0003);
      wr(sstx_pkg::ADDR_DATA, 32'h0000_000B);
      repeat (40) @(posedge mclk);
      clk_en <= 1'b0;
      @(negedge mclk);
      frz = {sclk, sdo};
      n = u_sstx_eeprom_model.nbits;
      repeat (20) @(posedge mclk);
      @(negedge mclk);
      chk({sclk, sdo}, frz);
      chk(u_sstx_eeprom_model.nbits, n);
      chk(awready, 1'b0);
      @(posedge mclk);
      clk_en <= 1'b1;
      poll(32'h0000_0008);
      chk(u_sstx_eeprom_model.got[5], 8'hD0);
      // polarity one idles the clock low, zero idles it high
      wr(sstx_pkg::ADDR_MODE, 32'h0000_00C3);
      @(negedge mclk);
      chk(sclk, 1'b0);
      wr(sstx_pkg::ADDR_MODE, 32'h0000_0083);
      @(negedge mclk);
      chk(sclk, 1'b1);
      // closing the command
      wr(sstx_pkg::ADDR_PORT, 32'h0000_0001); chk(sel, 1'b1);
      wr(sstx_pkg::ADDR_CTRL, 32'h0000_0000);
      wr(sstx_pkg::ADDR_DATA, 32'h0000_0099);
      repeat (300) @(posedge mclk);
      chk(sclk, 1'b1); chk(u_sstx_eeprom_model.got.size(), 6);
      conclude();
   end
endmodule
